/* File: design/hbd_chain.sv */
// half-band decimation chain of one downconverter channel with axi4-lite control
`timescale 1ns/1ps
module hbd_chain (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [hbd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hbd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_valid,
    output logic in_ready,
    input wire hbd_pkg::hbd_iq_t in_iq,
    output logic out_valid,
    input wire logic out_ready,
    output hbd_pkg::hbd_iq_t out_iq
);
    logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt, wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [hbd_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [1:0] dec;
    logic real_en, gain_en, run;
    logic s1_v, s2_v, s3_v, hb1_v, c2r_v_r, c2r_v_nxt, g_v_r, g_v_nxt;
    hbd_pkg::hbd_iq_t s1_iq, s2_iq, s3_iq, hb1_iq, c2r_iq_r, c2r_iq_nxt, g_iq_r, g_iq_nxt;
    logic [1:0] mix_ph_r, mix_ph_nxt;
    logic th_ph_r, th_ph_nxt;
    logic [hbd_pkg::FIFO_LW-1:0] level;
    logic [31:0] status;

    // 0: control, 1: status, 2: unmapped
    function automatic logic [1:0] reg_sel(input logic [hbd_pkg::ADDR_W-1:0] a);
        if (a == hbd_pkg::ADDR_CTRL) begin
            return 2'h0;
        end else if (a == hbd_pkg::ADDR_STATUS) begin
            return 2'h1;
        end
        return 2'h2;
    endfunction

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign dec = ctrl_r[hbd_pkg::CTRL_DEC_LSB +: 2];
    assign real_en = ctrl_r[hbd_pkg::CTRL_REAL_BIT];
    assign gain_en = ctrl_r[hbd_pkg::CTRL_GAIN_BIT];
    assign in_ready = run;

    always_comb begin
        status = '0;
        status[hbd_pkg::STAT_LVL_LSB +: hbd_pkg::FIFO_LW] = level;
        status[hbd_pkg::STAT_FULL_BIT] = !run;
        status[hbd_pkg::STAT_EMPTY_BIT] = !out_valid;
    end

    // one write and one read in flight; address and data may come in either order
    always_comb begin
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        ctrl_nxt = ctrl_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && awready_r) begin
            aw_got_nxt = 1'b1;
            awready_nxt = 1'b0;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_got_nxt = 1'b1;
            wready_nxt = 1'b0;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (aw_got_r && w_got_r && !bvalid_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = hbd_pkg::RESP_OKAY;
            if (reg_sel(awaddr_r) == 2'h0) begin
                if (wstrb_r[0]) begin
                    ctrl_nxt = wdata_r[7:0] & hbd_pkg::CTRL_MASK;
                end
            end else if (reg_sel(awaddr_r) == 2'h2) begin
                bresp_nxt = hbd_pkg::RESP_SLVERR;
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
        end
        if (s_axi_arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = hbd_pkg::RESP_OKAY;
            rdata_nxt = '0;
            if (reg_sel(s_axi_araddr) == 2'h0) begin
                rdata_nxt[7:0] = ctrl_r;
            end else if (reg_sel(s_axi_araddr) == 2'h1) begin
                rdata_nxt = status;
            end else begin
                rresp_nxt = hbd_pkg::RESP_SLVERR;
            end
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= hbd_pkg::RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            ctrl_r <= hbd_pkg::CTRL_RESET;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= hbd_pkg::RESP_OKAY;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            ctrl_r <= ctrl_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // the whole chain freezes while the fifo is full, so nothing in flight is lost
    hbd_halfband #(.NP(hbd_pkg::FIRST_NP), .CENTER(hbd_pkg::FIRST_CENTER),
        .COEF(hbd_pkg::FIRST_COEF)) u_halfband_stage_first (
        .aclk(aclk), .aresetn(aresetn), .run(run),
        .bypass(dec != hbd_pkg::DEC_ALL), .decim(1'b1),
        .in_v(in_valid), .in_iq(in_iq), .out_v(s1_v), .out_iq(s1_iq));
    hbd_halfband #(.NP(hbd_pkg::SECOND_NP), .CENTER(hbd_pkg::SECOND_CENTER),
        .COEF(hbd_pkg::SECOND_COEF)) u_halfband_stage_second (
        .aclk(aclk), .aresetn(aresetn), .run(run),
        .bypass(!(dec == hbd_pkg::DEC_ALL || dec == hbd_pkg::DEC_THREE)), .decim(1'b1),
        .in_v(s1_v), .in_iq(s1_iq), .out_v(s2_v), .out_iq(s2_iq));
    hbd_halfband #(.NP(hbd_pkg::THIRD_NP), .CENTER(hbd_pkg::THIRD_CENTER),
        .COEF(hbd_pkg::THIRD_COEF)) u_halfband_stage_third (
        .aclk(aclk), .aresetn(aresetn), .run(run),
        .bypass(dec == hbd_pkg::DEC_FINAL), .decim(1'b1),
        .in_v(s2_v), .in_iq(s2_iq), .out_v(s3_v), .out_iq(s3_iq));
    hbd_halfband #(.NP(hbd_pkg::FINAL_NP), .CENTER(hbd_pkg::FINAL_CENTER),
        .COEF(hbd_pkg::FINAL_COEF)) u_halfband_stage_final (
        .aclk(aclk), .aresetn(aresetn), .run(run),
        .bypass(1'b0), .decim(!real_en),
        .in_v(s3_v), .in_iq(s3_iq), .out_v(hb1_v), .out_iq(hb1_iq));

    // quarter-rate upconversion: real part walks i, -q, -i, q
    always_comb begin
        c2r_v_nxt = c2r_v_r;
        c2r_iq_nxt = c2r_iq_r;
        mix_ph_nxt = real_en ? mix_ph_r : 2'h0;
        // shadow of the third stage's pair phase, kept only for a_third_used
        th_ph_nxt = (run && s2_v && dec != hbd_pkg::DEC_FINAL) ? !th_ph_r : th_ph_r;
        if (run) begin
            c2r_v_nxt = hb1_v;
            if (hb1_v && real_en) begin
                mix_ph_nxt = 2'(mix_ph_r + 1'b1);
                c2r_iq_nxt.q = '0;
                case (mix_ph_r)
                    2'h0: c2r_iq_nxt.i = hb1_iq.i;
                    2'h1: c2r_iq_nxt.i = hbd_pkg::hbd_sat(-hbd_pkg::AW'(hb1_iq.q));
                    2'h2: c2r_iq_nxt.i = hbd_pkg::hbd_sat(-hbd_pkg::AW'(hb1_iq.i));
                    default: c2r_iq_nxt.i = hb1_iq.q;
                endcase
            end else if (hb1_v) begin
                c2r_iq_nxt = hb1_iq;
            end
        end
    end

    // a shift clips at full scale instead of wrapping
    always_comb begin
        g_v_nxt = g_v_r;
        g_iq_nxt = g_iq_r;
        if (run) begin
            g_v_nxt = c2r_v_r;
            if (c2r_v_r && gain_en) begin
                g_iq_nxt.i = hbd_pkg::hbd_sat(hbd_pkg::AW'(c2r_iq_r.i) <<< 1);
                g_iq_nxt.q = hbd_pkg::hbd_sat(hbd_pkg::AW'(c2r_iq_r.q) <<< 1);
            end else if (c2r_v_r) begin
                g_iq_nxt = c2r_iq_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c2r_v_r <= 1'b0;
            c2r_iq_r <= '0;
            mix_ph_r <= 2'h0;
            th_ph_r <= 1'b0;
            g_v_r <= 1'b0;
            g_iq_r <= '0;
        end else begin
            c2r_v_r <= c2r_v_nxt;
            c2r_iq_r <= c2r_iq_nxt;
            mix_ph_r <= mix_ph_nxt;
            th_ph_r <= th_ph_nxt;
            g_v_r <= g_v_nxt;
            g_iq_r <= g_iq_nxt;
        end
    end

    hbd_fifo #(.W($bits(hbd_pkg::hbd_iq_t)), .DEPTH(hbd_pkg::FIFO_DEPTH)) u_fifo (
        .aclk(aclk), .aresetn(aresetn),
        .in_valid(g_v_r), .in_ready(run), .in_data(g_iq_r),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_iq),
        .level(level));

    property p_b_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_first_bypass;
        @(posedge aclk) disable iff (!aresetn)
        run && in_valid && dec != hbd_pkg::DEC_ALL |=> s1_v && s1_iq == $past(in_iq);
    endproperty
    a_first_bypass: assert property (p_first_bypass) else $error("first stage not bypassed");
    property p_third_used;
        @(posedge aclk) disable iff (!aresetn)
        run && s2_v && dec != hbd_pkg::DEC_FINAL |=> s3_v == $past(th_ph_r);
    endproperty
    a_third_used: assert property (p_third_used) else $error("third stage not decimating");
    property p_q_zero;
        @(posedge aclk) disable iff (!aresetn)
        run && hb1_v && real_en |=> c2r_v_r && c2r_iq_r.q == '0;
    endproperty
    a_q_zero: assert property (p_q_zero) else $error("quadrature not dropped");
    property p_mix_neg;
        @(posedge aclk) disable iff (!aresetn)
        run && hb1_v && real_en && mix_ph_r == 2'h2 && hb1_iq.i != hbd_pkg::SMIN
            |=> c2r_iq_r.i == -$past(hb1_iq.i);
    endproperty
    a_mix_neg: assert property (p_mix_neg) else $error("quarter-rate mixer sign wrong");
    property p_gain_sat;
        @(posedge aclk) disable iff (!aresetn)
        run && c2r_v_r && gain_en && c2r_iq_r.i > (hbd_pkg::SMAX >>> 1)
            |=> g_iq_r.i == hbd_pkg::SMAX;
    endproperty
    a_gain_sat: assert property (p_gain_sat) else $error("gain stage wrapped");
    property p_gain_unity;
        @(posedge aclk) disable iff (!aresetn)
        run && c2r_v_r && !gain_en |=> g_v_r && g_iq_r == $past(c2r_iq_r);
    endproperty
    a_gain_unity: assert property (p_gain_unity) else $error("0 dB gain altered sample");
    c_real_out: cover property (@(posedge aclk) disable iff (!aresetn) g_v_r && real_en);
    c_dec_all: cover property (@(posedge aclk) disable iff (!aresetn)
        hb1_v && dec == hbd_pkg::DEC_ALL);
    c_ctrl_write: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready && ctrl_r != hbd_pkg::CTRL_RESET);
endmodule

/* File: design/hbd_pkg.sv */
// shared constants, types and helpers for the half-band decimation chain
package hbd_pkg;
    localparam int DW = 16;
    localparam int CW = 22;
    localparam int AW = 48;
    localparam int NPMAX = 14;
    typedef struct packed {
        logic signed [DW-1:0] i;
        logic signed [DW-1:0] q;
    } hbd_iq_t;
    typedef logic signed [CW-1:0] hbd_coef_t;
    typedef hbd_coef_t hbd_coefs_t [NPMAX];
    // outer coefficients from the edge inward; zero taps are implied by the half-band form
    localparam int FIRST_NP = 3;
    localparam int FIRST_CENTER = 8192;
    localparam hbd_coefs_t FIRST_COEF = '{0: 99, 1: -808, 2: 4805, default: 0};
    localparam int SECOND_NP = 3;
    localparam int SECOND_CENTER = 65536;
    localparam hbd_coefs_t SECOND_COEF = '{0: 859, 1: -6661, 2: 38570, default: 0};
    localparam int THIRD_NP = 5;
    localparam int THIRD_CENTER = 131072;
    localparam hbd_coefs_t THIRD_COEF = '{0: 161, 1: -1328, 2: 5814, 3: -19272, 4: 80160,
        default: 0};
    localparam int FINAL_NP = 14;
    localparam int FINAL_CENTER = 524288;
    localparam hbd_coefs_t FINAL_COEF = '{-24, 102, -302, 730, -1544, 2964, -5284, 8903,
        -14383, 22640, -35476, 57468, -105442, 331792};
    localparam logic signed [DW-1:0] SMAX = 16'h7FFF;
    localparam logic signed [DW-1:0] SMIN = 16'h8000;
    // control register fields
    localparam int CTRL_DEC_LSB = 0;
    localparam int CTRL_REAL_BIT = 3;
    localparam int CTRL_GAIN_BIT = 6;
    localparam logic [7:0] CTRL_MASK = 8'h4B;
    localparam logic [7:0] CTRL_RESET = 8'h03;
    localparam logic [1:0] DEC_FINAL = 2'h3;
    localparam logic [1:0] DEC_TWO = 2'h0;
    localparam logic [1:0] DEC_THREE = 2'h1;
    localparam logic [1:0] DEC_ALL = 2'h2;
    // register map
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int STAT_LVL_LSB = 0;
    localparam int STAT_FULL_BIT = 4;
    localparam int STAT_EMPTY_BIT = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_LW = $clog2(FIFO_DEPTH) + 1;

    function automatic logic signed [DW-1:0] hbd_sat(input logic signed [AW-1:0] v);
        if (v > AW'(SMAX)) begin
            return SMAX;
        end else if (v < AW'(SMIN)) begin
            return SMIN;
        end
        return v[DW-1:0];
    endfunction
endpackage

/* File: design/hbd_fifo.sv */
// parameterised sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module hbd_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop, rdy_r, rdy_nxt, val_r, val_nxt;

    // flags are registered from the next count so both ports leave flip-flops
    assign in_ready = rdy_r;
    assign out_valid = val_r;
    assign out_data = mem[rp_r];
    assign level = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? PW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? PW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (PW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (PW+1)'(cnt_r - 1'b1);
        end
        rdy_nxt = (cnt_nxt != (PW+1)'(DEPTH));
        val_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
            val_r <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            val_r <= val_nxt;
        end
    end

    // storage needs no reset; only words below the count are ever read
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    property p_fifo_fill;
        @(posedge aclk) disable iff (!aresetn)
        push && !pop |=> level == $past(level) + 1'b1;
    endproperty
    a_fifo_fill: assert property (p_fifo_fill) else $error("fifo level did not rise on push");
    c_fifo_full: cover property (@(posedge aclk) disable iff (!aresetn) !in_ready);
endmodule

/* File: design/hbd_halfband.sv */
// one decimate-by-2 half-band stage with bypass and no-decimate modes
`timescale 1ns/1ps
module hbd_halfband #(
    parameter int NP = 3,
    parameter int CENTER = 8192,
    parameter hbd_pkg::hbd_coefs_t COEF = '{default: 0}
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic bypass,
    input wire logic decim,
    input wire logic in_v,
    input wire hbd_pkg::hbd_iq_t in_iq,
    output logic out_v,
    output hbd_pkg::hbd_iq_t out_iq
);
    localparam int N = 4 * NP - 1;
    localparam int MID = 2 * NP - 1;
    localparam int SH = $clog2(CENTER) + 1;
    typedef logic signed [hbd_pkg::DW-1:0] hbd_win_t [N];
    hbd_win_t ti_r, ti_nxt, tq_r, tq_nxt, wi, wq;
    logic ph_r, ph_nxt, ov_r, ov_nxt;
    hbd_pkg::hbd_iq_t oiq_r, oiq_nxt;

    // symmetric folding halves the multipliers; zero taps are skipped
    function automatic logic signed [hbd_pkg::DW-1:0] fir(input hbd_win_t w);
        logic signed [hbd_pkg::AW-1:0] acc;
        acc = hbd_pkg::AW'(CENTER) * hbd_pkg::AW'(w[MID]);
        for (int k = 0; k < NP; k++) begin
            acc = acc + hbd_pkg::AW'(COEF[k])
                * (hbd_pkg::AW'(w[2*k]) + hbd_pkg::AW'(w[N-1-2*k]));
        end
        acc = acc + (hbd_pkg::AW'(1) <<< (SH - 1));
        return hbd_pkg::hbd_sat(acc >>> SH);
    endfunction

    assign out_v = ov_r;
    assign out_iq = oiq_r;

    always_comb begin
        ti_nxt = ti_r;
        tq_nxt = tq_r;
        ph_nxt = ph_r;
        ov_nxt = ov_r;
        oiq_nxt = oiq_r;
        wi[0] = in_iq.i;
        wq[0] = in_iq.q;
        for (int k = 1; k < N; k++) begin
            wi[k] = ti_r[k-1];
            wq[k] = tq_r[k-1];
        end
        if (run) begin
            ov_nxt = 1'b0;
            if (in_v && bypass) begin
                ov_nxt = 1'b1;
                oiq_nxt = in_iq;
            end else if (in_v) begin
                ti_nxt = wi;
                tq_nxt = wq;
                ph_nxt = decim ? !ph_r : 1'b0;
                if (!decim || ph_r) begin
                    ov_nxt = 1'b1;
                    oiq_nxt.i = fir(wi);
                    oiq_nxt.q = fir(wq);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < N; k++) begin
                ti_r[k] <= '0;
                tq_r[k] <= '0;
            end
            ph_r <= 1'b0;
            ov_r <= 1'b0;
            oiq_r <= '0;
        end else begin
            ti_r <= ti_nxt;
            tq_r <= tq_nxt;
            ph_r <= ph_nxt;
            ov_r <= ov_nxt;
            oiq_r <= oiq_nxt;
        end
    end

    property p_bypass_pass;
        @(posedge aclk) disable iff (!aresetn)
        run && in_v && bypass |=> out_v && out_iq == $past(in_iq);
    endproperty
    a_bypass_pass: assert property (p_bypass_pass) else $error("bypass did not pass sample");
    property p_decim_skip;
        @(posedge aclk) disable iff (!aresetn)
        run && in_v && !bypass && decim && !ph_r |=> !out_v ##0 ph_r;
    endproperty
    a_decim_skip: assert property (p_decim_skip) else $error("first of pair produced output");
    property p_no_decim;
        @(posedge aclk) disable iff (!aresetn)
        run && in_v && !bypass && !decim |=> out_v;
    endproperty
    a_no_decim: assert property (p_no_decim) else $error("rate kept stage dropped a sample");
endmodule

/* File: tb/hbd_far.sv */
// far-side model: sample source upstream and formatter sink downstream
`timescale 1ns/1ps
module hbd_far (
    input wire logic aclk,
    input wire logic aresetn,
    output logic in_valid,
    input wire logic in_ready,
    output hbd_pkg::hbd_iq_t in_iq,
    input wire logic out_valid,
    output logic out_ready,
    input wire hbd_pkg::hbd_iq_t out_iq
);
    int quota = 0;
    int sent = 0;
    int got = 0;
    int qnz = 0;
    logic stall = 1'b0;
    hbd_pkg::hbd_iq_t smp = '0;
    hbd_pkg::hbd_iq_t last = '0;
    logic signed [15:0] hist [4] = '{default: '0};
    initial begin
        in_valid = 1'b0;
        out_ready = 1'b0;
        in_iq = '0;
    end
    always @(posedge aclk) begin
        // a sample stays offered until taken, one strobe per sample
        if (in_valid && in_ready) sent = sent + 1;
        in_valid <= aresetn && sent < quota;
        // idle lines toggle so a stale word never passes for data
        in_iq <= (aresetn && sent < quota) ? smp : ~in_iq;
        if (out_valid && out_ready) begin
            got = got + 1;
            qnz = qnz + int'(out_iq.q !== 16'h0000);
            last = out_iq;
            hist = '{hist[1], hist[2], hist[3], out_iq.i};
        end
        out_ready <= aresetn && !stall;
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the half-band decimation chain
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] CT = hbd_pkg::ADDR_CTRL;
    localparam logic [3:0] ST = hbd_pkg::ADDR_STATUS;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_valid, in_ready, out_valid, out_ready;
    hbd_pkg::hbd_iq_t in_iq, out_iq;
    int num_errors = 0;
    int checks_done = 0;
    int g0;
    always #50 aclk = ~aclk;
    hbd_chain hbd_chain_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .in_ready, .in_iq,
        .out_valid, .out_ready, .out_iq);
    hbd_far hbd_far_i (.aclk, .aresetn, .in_valid, .in_ready, .in_iq, .out_valid,
        .out_ready, .out_iq);
    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // waits until sending is done and the output has been quiet for a while
    task automatic run(input logic [31:0] c, input logic [31:0] iq, input int n);
        int k;
        wr(CT, c, 4'hF);
        g0 = hbd_far_i.got;
        hbd_far_i.smp = iq;
        hbd_far_i.quota += n;
        k = 0;
        while (k < 24) begin
            @(posedge aclk);
            k = (out_valid === 1'b1 || hbd_far_i.sent < hbd_far_i.quota) ? 0 : k + 1;
        end
    endtask
    initial begin
        int s;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CT);
        chk(d, 32'h0000_0003);
        rd(4'h8);
        chk2(r, hbd_pkg::RESP_SLVERR);
        wr(CT, 32'hFFFF_FFFF, 4'hF);
        wr(CT, 32'h0000_0000, 4'h0);
        wr(ST, 32'h0000_0000, 4'hF);
        chk2(r, hbd_pkg::RESP_OKAY);
        wr(4'hC, 32'h0000_0000, 4'hF);
        chk2(r, hbd_pkg::RESP_SLVERR);
        rd(CT);
        chk(d, 32'h0000_004B);
        // complex then real output, every decimation code
        for (int m = 0; m < 8; m++) begin
            s = (m % 4 == 3) ? 1 - m / 4 : m % 4 + 2 - m / 4;
            if (m == 4) hbd_far_i.qnz = 0;
            run({28'h0, 1'(m / 4), 1'b0, 2'(m % 4)}, 32'h1000_0800, 64);
            chk(hbd_far_i.got - g0, 64 >> s);
        end
        chk(hbd_far_i.qnz, 32'h0);
        chk(32'(hbd_far_i.hist[0] + hbd_far_i.hist[2]), 32'h0);
        chk(32'(hbd_far_i.hist[1] + hbd_far_i.hist[3]), 32'h0);
        chk(32'(hbd_far_i.hist[0] * hbd_far_i.hist[0] + hbd_far_i.hist[1] *
            hbd_far_i.hist[1]), 32'h0140_0000);
        for (int m = 0; m < 3; m++) begin
            // the all-stage run is long enough to flush every window with the new level
            run(m ? 32'h43 : 32'h02, m == 2 ? 32'h5000_B000 : 32'h3000_D000,
                m ? 64 : 1024);
            d = m == 0 ? 32'h3000_D000 : m == 1 ? 32'h6000_A000 : 32'h7FFF_8000;
            chk(hbd_far_i.last, d);
        end
        // stalled sink: fifo fills, chain refuses, then drains empty
        hbd_far_i.stall = 1'b1;
        wr(CT, 32'h0000_000B, 4'hF);
        s = hbd_far_i.got;
        hbd_far_i.quota += 20;
        while (in_ready !== 1'b0) @(posedge aclk);
        rd(ST);
        chk(d, 32'h0000_0018);
        hbd_far_i.stall = 1'b0;
        run(32'h0000_000B, 32'h1000_0800, 0);
        rd(ST);
        chk(d, 32'h0000_0020);
        chk(hbd_far_i.got - s, 32'd20);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        finish_test();
    end
endmodule
